// File: verilog/dram_init_regs.svh
// Functional notes
// - Clock enable stays low 500 us after reset release; device initialises itself.
// - Termination stays high impedance in reset and until clock enable seen high.
// - Mode registers undefined after reset; all four must be written.
// - Mode sets and DLL reset never disturb array contents.
// - DLL reset bit clears itself; DLL use waits for lock time.
`ifndef DRAM_INIT_REGS_SVH
`define DRAM_INIT_REGS_SVH

// Clock and timing figures
`define CLK_PERIOD_NS 40
`define T_RST_PWR_US 200
`define T_RST_STABLE_NS 100
`define T_INIT_US 500
`define T_CKE_LOW_NS 10
`define NS2CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define TXS_CYC 8
`define TXPR_MIN_CYC 5
`define TMRD_CYC 4
`define TMOD_CYC 12
`define TDLLK_CYC 512
`define TZQINIT_CYC 512
`define RTT_NOM_MASK 14'h0244

// Register offsets
`define REG_STATUS 4'h0
`define REG_ERR 4'h1
`define REG_CTRL 4'h2
`define REG_MR0 4'h4
`define REG_MR1 4'h5
`define REG_MR2 4'h6
`define REG_MR3 4'h7
`define CTRL_RST_VAL 1'b0

// Error flag positions
`define ERR_RST_SHORT 0
`define ERR_CKE_AT_REL 1
`define ERR_CKE_EARLY 2
`define ERR_NO_NOP 3
`define ERR_CKE_DROP 4
`define ERR_ODT_MOVE 5
`define ERR_MRS_EARLY 6
`define ERR_ORDER 7
`define ERR_INIT_BITS 8
`define ERR_BAD_CMD 9
`define ERR_MRD 10
`define ERR_MOD 11
`define ERR_NOT_IDLE 12
`define ERR_BA2 13
`define ERR_W 14

`endif

// File: verilog/dram_init_pkg.sv
package dram_init_pkg;
   typedef enum logic [2:0] {
      ST_RESET, ST_SELF_INIT, ST_WAIT_CKE, ST_XPR, ST_MRS, ST_ZQ, ST_LOCK, ST_READY
   } init_state_t;
   typedef enum logic [2:0] {
      CMD_DES, CMD_NOP, CMD_MRS, CMD_ZQCL, CMD_ZQCS, CMD_OTHER
   } cmd_t;
endpackage : dram_init_pkg

// File: verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t s_q, s_d;

   // First stage feeds only the second
   always_comb begin
      s_d.s1 = i_d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_q = s_q.s2;
endmodule : pin_sync

// File: verilog/wait_timer.sv
`timescale 1ns/1ps
module wait_timer #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [W-1:0] i_value,
   output logic o_done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_t;
   tmr_t s_q, s_d;

   // Load or count down to zero and hold
   always_comb begin
      s_d = s_q;
      if (i_load) begin
         s_d.cnt = i_value;
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_done = (s_q.cnt == '0) && !i_load;
endmodule : wait_timer

// File: verilog/dram_init_seq.sv
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "dram_init_regs.svh"
module dram_init_seq
   import dram_init_pkg::*;
#(
   parameter int RST_PWR_CYC = `NS2CYC(`T_RST_PWR_US * 1000),
   parameter int INIT_WAIT_CYC = `NS2CYC(`T_INIT_US * 1000),
   parameter int TXS_CYC = `TXS_CYC,
   parameter int TMRD_CYC = `TMRD_CYC,
   parameter int TMOD_CYC = `TMOD_CYC,
   parameter int TDLLK_CYC = `TDLLK_CYC,
   parameter int TZQINIT_CYC = `TZQINIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_reset_n,
   input wire logic i_cke,
   input wire logic i_cs_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic [2:0] i_ba,
   input wire logic [13:0] i_a,
   input wire logic i_odt,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_ready,
   output logic o_dll_locked,
   output logic o_term_en,
   output logic o_err
);
   localparam int TW = 16;
   localparam int RST_STB_CYC = `NS2CYC(`T_RST_STABLE_NS);
   localparam int TXPR_CYC = (TXS_CYC > `TXPR_MIN_CYC) ? TXS_CYC : `TXPR_MIN_CYC;

   typedef struct packed {
      init_state_t state;
      logic [1:0] step;
      logic [3:0][13:0] mr;
      logic [3:0] mr_valid;
      logic pwr_up;
      logic [TW-1:0] rst_len;
      logic cke_prev;
      logic prev_idle;
      logic odt_hold;
      logic cke_seen;
      logic [7:0] mrd_cnt;
      logic [7:0] mod_cnt;
      logic [TW-1:0] dll_cnt;
      logic dll_locked;
      logic dll_rst_pend;
      logic [`ERR_W-1:0] err;
      logic strict;
      logic ready;
      logic term_en;
      logic [31:0] rdata;
   } seq_t;
   seq_t s_q, s_d;

   logic reset_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s;
   logic [2:0] ba_s;
   logic [13:0] a_s;
   logic tmr_load;
   logic [TW-1:0] tmr_val;
   logic tmr_done;

   // Pins come from the controller's domain
   pin_sync #(.W(24), .RST_VAL(24'h000000)) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d({i_reset_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_a, i_odt}),
      .o_q({reset_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s, odt_s})
   );

   // Phase timer for the long waits
   wait_timer #(.W(TW)) u_tmr (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(tmr_load),
      .i_value(tmr_val),
      .o_done(tmr_done)
   );

   // Command decode from strobes, calibration length on A10
   function automatic cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                       input logic cas_n, input logic we_n,
                                       input logic a10);
      cmd_t c;
      c = CMD_OTHER;
      if (cs_n) begin
         c = CMD_DES;
      end else if ({ras_n, cas_n, we_n} == 3'b111) begin
         c = CMD_NOP;
      end else if ({ras_n, cas_n, we_n} == 3'b000) begin
         c = CMD_MRS;
      end else if ({ras_n, cas_n, we_n} == 3'b110) begin
         c = a10 ? CMD_ZQCL : CMD_ZQCS;
      end
      return c;
   endfunction : cmd_decode

   // Register index expected at each init step: MR2, MR3, MR1, MR0
   function automatic logic [1:0] step_reg(input logic [1:0] step);
      logic [1:0] r;
      r = 2'h0;
      unique case (step)
         2'h0: r = 2'h2;
         2'h1: r = 2'h3;
         2'h2: r = 2'h1;
         2'h3: r = 2'h0;
      endcase
      return r;
   endfunction : step_reg

   cmd_t cmd;
   logic is_idle;
   logic [`ERR_W-1:0] err_set;
   logic mrs_bad;
   logic in_init;

   always_comb begin
      s_d = s_q;
      err_set = '0;
      mrs_bad = 1'b0;
      tmr_load = 1'b0;
      tmr_val = '0;
      cmd = cmd_decode(cs_n_s, ras_n_s, cas_n_s, we_n_s, a_s[10]);
      is_idle = (cmd == CMD_DES) || (cmd == CMD_NOP);
      in_init = (s_q.state == ST_XPR) || (s_q.state == ST_MRS) ||
                (s_q.state == ST_ZQ) || (s_q.state == ST_LOCK);
      s_d.cke_prev = cke_s;
      s_d.prev_idle = is_idle;
      s_d.rdata = '0;

      // Gap counters and DLL lock count
      if (s_q.mrd_cnt != '0) s_d.mrd_cnt = s_q.mrd_cnt - 8'h01;
      if (s_q.mod_cnt != '0) s_d.mod_cnt = s_q.mod_cnt - 8'h01;
      if (s_q.dll_cnt != '0) begin
         s_d.dll_cnt = s_q.dll_cnt - 1'b1;
         if (s_q.dll_cnt == TW'(1)) s_d.dll_locked = 1'b1;
      end
      if (s_q.dll_rst_pend) begin
         s_d.mr[0][8] = 1'b0;
         s_d.dll_rst_pend = 1'b0;
      end

      // Checks that hold throughout the init window
      if (in_init) begin
         if (!cke_s) err_set[`ERR_CKE_DROP] = 1'b1;
         if (odt_s != s_q.odt_hold) err_set[`ERR_ODT_MOVE] = 1'b1;
         if (odt_s && s_q.mr_valid[1] && ((s_q.mr[1] & `RTT_NOM_MASK) != 14'h0000)) begin
            err_set[`ERR_ODT_MOVE] = 1'b1;
         end
      end

      // Mode set timing, decode and storage
      if (cmd == CMD_MRS && (s_q.state == ST_MRS || s_q.state == ST_READY)) begin
         if (s_q.mrd_cnt != '0) begin
            err_set[`ERR_MRD] = 1'b1;
            mrs_bad = 1'b1;
         end
         if (ba_s[2]) begin
            err_set[`ERR_BA2] = 1'b1;
            mrs_bad = 1'b1;
         end
         if (s_q.state == ST_MRS) begin
            if (ba_s[1:0] != step_reg(s_q.step)) begin
               err_set[`ERR_ORDER] = 1'b1;
               mrs_bad = 1'b1;
            end
            if ((ba_s[1:0] == 2'h1 && a_s[0]) || (ba_s[1:0] == 2'h0 && !a_s[8])) begin
               err_set[`ERR_INIT_BITS] = 1'b1;
               mrs_bad = 1'b1;
            end
         end
         if (!(mrs_bad && s_q.strict)) begin
            s_d.mr[ba_s[1:0]] = a_s;
            s_d.mr_valid[ba_s[1:0]] = 1'b1;
            s_d.mrd_cnt = 8'(TMRD_CYC);
            s_d.mod_cnt = 8'(TMOD_CYC);
            if (ba_s[1:0] == 2'h0 && a_s[8]) begin
               s_d.dll_rst_pend = 1'b1;
               s_d.dll_cnt = TW'(TDLLK_CYC);
               s_d.dll_locked = 1'b0;
            end
            if (s_q.state == ST_MRS) begin
               s_d.step = s_q.step + 2'h1;
               if (s_q.step == 2'h3) s_d.state = ST_ZQ;
            end
         end
      end else if (!is_idle && s_q.mod_cnt != '0) begin
         err_set[`ERR_MOD] = 1'b1;
      end

      // Reset pin overrides the whole sequence
      if (!reset_n_s) begin
         s_d.state = ST_RESET;
         s_d.mr_valid = '0;
         s_d.cke_seen = 1'b0;
         s_d.ready = 1'b0;
         s_d.dll_locked = 1'b0;
         s_d.dll_cnt = '0;
         s_d.mrd_cnt = '0;
         s_d.mod_cnt = '0;
         if (s_q.rst_len != '1) s_d.rst_len = s_q.rst_len + 1'b1;
      end else begin
         unique case (s_q.state)
            ST_RESET: begin
               if (s_q.rst_len < (s_q.pwr_up ? TW'(RST_PWR_CYC) : TW'(RST_STB_CYC))) begin
                  err_set[`ERR_RST_SHORT] = 1'b1;
               end
               if (s_q.cke_prev) err_set[`ERR_CKE_AT_REL] = 1'b1;
               s_d.pwr_up = 1'b0;
               s_d.rst_len = '0;
               s_d.state = ST_SELF_INIT;
               tmr_load = 1'b1;
               tmr_val = TW'(INIT_WAIT_CYC);
            end
            ST_SELF_INIT: begin
               if (cke_s) err_set[`ERR_CKE_EARLY] = 1'b1;
               if (tmr_done) s_d.state = ST_WAIT_CKE;
            end
            ST_WAIT_CKE: begin
               if (cke_s) begin
                  if (!s_q.prev_idle) err_set[`ERR_NO_NOP] = 1'b1;
                  s_d.cke_seen = 1'b1;
                  s_d.odt_hold = odt_s;
                  s_d.state = ST_XPR;
                  tmr_load = 1'b1;
                  tmr_val = TW'(TXPR_CYC);
               end
            end
            ST_XPR: begin
               if (cmd == CMD_MRS) err_set[`ERR_MRS_EARLY] = 1'b1;
               if (tmr_done) begin
                  s_d.state = ST_MRS;
                  s_d.step = 2'h0;
               end
            end
            ST_MRS: begin
               if (!is_idle && cmd != CMD_MRS) err_set[`ERR_BAD_CMD] = 1'b1;
            end
            ST_ZQ: begin
               if (cmd == CMD_ZQCL) begin
                  s_d.state = ST_LOCK;
                  tmr_load = 1'b1;
                  tmr_val = TW'(TZQINIT_CYC);
               end else if (!is_idle && cmd != CMD_MRS) begin
                  err_set[`ERR_BAD_CMD] = 1'b1;
               end
            end
            ST_LOCK: begin
               if (tmr_done && s_q.dll_locked) begin
                  s_d.state = ST_READY;
                  s_d.ready = 1'b1;
               end
            end
            ST_READY: begin
               if (cmd == CMD_MRS && !cke_s) err_set[`ERR_NOT_IDLE] = 1'b1;
            end
         endcase
      end

      // Termination stays off until clock enable seen high
      s_d.term_en = s_d.cke_seen && reset_n_s && odt_s && s_d.mr_valid[1] &&
                    ((s_d.mr[1] & `RTT_NOM_MASK) != 14'h0000);

      // Register port: sticky errors, write one to clear, set wins
      s_d.err = s_q.err | err_set;
      if (i_wr && i_addr == `REG_ERR) begin
         s_d.err = (s_q.err & ~i_wdata[`ERR_W-1:0]) | err_set;
      end
      if (i_wr && i_addr == `REG_CTRL) s_d.strict = i_wdata[0];
      if (i_rd) begin
         unique case (i_addr)
            `REG_STATUS: s_d.rdata = {19'h00000, s_q.step, s_q.state, s_q.mr_valid,
                                      s_q.cke_seen, s_q.term_en, s_q.dll_locked, s_q.ready};
            `REG_ERR: s_d.rdata = {{(32 - `ERR_W){1'b0}}, s_q.err};
            `REG_CTRL: s_d.rdata = {31'h00000000, s_q.strict};
            `REG_MR0: s_d.rdata = {18'h00000, s_q.mr[0]};
            `REG_MR1: s_d.rdata = {18'h00000, s_q.mr[1]};
            `REG_MR2: s_d.rdata = {18'h00000, s_q.mr[2]};
            `REG_MR3: s_d.rdata = {18'h00000, s_q.mr[3]};
            default: s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.state <= ST_RESET;
         s_q.pwr_up <= 1'b1;
         s_q.strict <= `CTRL_RST_VAL;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign o_rdata = s_q.rdata;
   assign o_ready = s_q.ready;
   assign o_dll_locked = s_q.dll_locked;
   assign o_term_en = s_q.term_en;
   assign o_err = |s_q.err;
endmodule : dram_init_seq

// File: sim/dram_init_props.sv
`timescale 1ns/1ps
module dram_init_props (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_reset_n,
   input wire logic i_cke,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic o_ready,
   input wire logic o_dll_locked,
   input wire logic o_term_en,
   input wire logic o_err
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Termination, ready and lock follow the reset pin
   AST_TERM_RESET: assert property ((!i_reset_n) [*5] |-> !o_term_en)
      else $error("termination active while reset pin held");
   AST_READY_DROP: assert property ((!i_reset_n) [*5] |-> !o_ready && !o_dll_locked)
      else $error("ready or lock kept through reset pin");
   AST_TERM_CKE: assert property ($rose(o_term_en) |-> $past(i_cke, 3))
      else $error("termination enabled before clock enable seen");
   AST_LOCK_READY: assert property (o_ready |-> o_dll_locked)
      else $error("ready without lock");
   AST_READY_HOLD: assert property (o_ready && i_reset_n && $past(i_reset_n) &&
      $past(i_reset_n, 2) && $past(i_reset_n, 3) |=> o_ready)
      else $error("ready dropped without reset");
   AST_ERR_STICKY: assert property (o_err && !i_wr |=> o_err)
      else $error("error flag lost without clear");
   // Bus answers only in the cycle after a read
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read cycle");
   AST_RST_CLEARS: assert property ($fell(i_rst) |-> !o_ready && !o_err && !o_term_en)
      else $error("outputs not cleared by reset");
endmodule : dram_init_props

// File: sim/dram_ctrl_model.sv
`timescale 1ns/1ps
module dram_ctrl_model #(
   parameter int INIT_CYC = 20
) (
   input wire logic i_clk,
   output logic o_reset_n,
   output logic o_cke,
   output logic o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic [2:0] o_ba,
   output logic [13:0] o_a,
   output logic o_odt
);
   // Power-on state: reset pin low, no-op on the command pins
   initial begin
      o_reset_n = 1'b0;
      o_cke = 1'b0;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
      o_ba = 3'h0;
      o_a = 14'h0;
      o_odt = 1'b0;
   end

   // One command, then no-ops with a toggling address bus
   task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a,
      input int gap);
      @(posedge i_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
      o_ba <= ba;
      o_a <= a;
      repeat (gap) begin
         @(posedge i_clk);
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'h7;
         o_a <= ~o_a;
      end
   endtask : cmd

   // Level pins, changed just after an edge
   task automatic set_pins(input logic rst_n, input logic cke, input logic odt);
      @(posedge i_clk);
      o_reset_n <= rst_n;
      o_cke <= cke;
      o_odt <= odt;
   endtask : set_pins

   // Reset and full init; fault picks one deliberate violation
   task automatic run_init(input int fault, input int rst_cyc);
      logic [1:0] ord [4] = '{2'd2, 2'd3, 2'd1, 2'd0};
      logic [13:0] val [4] = '{14'h0100, 14'h0000, 14'h0008, 14'h0000};
      int gap;
      if (fault == 1) ord = '{2'd3, 2'd2, 2'd1, 2'd0};
      if (fault == 4) val[1] = 14'h0001;
      @(posedge i_clk);
      o_cke <= 1'b0;
      o_reset_n <= 1'b0;
      repeat (rst_cyc) @(posedge i_clk);
      o_reset_n <= 1'b1;
      repeat ((fault == 2) ? 4 : INIT_CYC + 3) @(posedge i_clk);
      cmd(4'h7, 3'h0, 14'h0, 1);
      o_cke <= 1'b1;
      cmd(4'h7, 3'h0, 14'h0, 10);
      foreach (ord[i]) begin
         gap = (fault == 3) ? 1 : 4;
         if (i == 3) gap = (fault == 5) ? 3 : 13;
         cmd(4'h0, {1'b0, ord[i]}, val[ord[i]], gap);
      end
      cmd(4'h6, 3'h0, 14'h0400, 2);
   endtask : run_init
endmodule : dram_ctrl_model

// File: sim/test_dram_init_and_mode_register_seq.sv
`timescale 1ns/1ps
`include "dram_init_regs.svh"
module test_dram_init_and_mode_register_seq;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reset_n, cke, cs_n, ras_n, cas_n, we_n, odt;
   logic [2:0] ba;
   logic [13:0] a;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic ready, dll_locked, term_en, err;
   int error_cnt = 0;
   int check_count = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   dram_init_seq #(.RST_PWR_CYC(10), .INIT_WAIT_CYC(20), .TDLLK_CYC(16), .TZQINIT_CYC(16))
   dram_init_seq_inst (.i_clk(clk), .i_rst(rst), .i_reset_n(reset_n), .i_cke(cke),
      .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_a(a),
      .i_odt(odt), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_ready(ready), .o_dll_locked(dll_locked), .o_term_en(term_en), .o_err(err));

   dram_ctrl_model #(.INIT_CYC(20)) dram_ctrl_model_inst (.i_clk(clk), .o_reset_n(reset_n),
      .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
      .o_ba(ba), .o_a(a), .o_odt(odt));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim

   // Register bus write and checked read
   task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata & m, e);
   endtask : rd_chk

   // Bounded wait for init complete
   task automatic wait_ready();
      int n = 0;
      while (ready !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n == 200) begin
         error_cnt++;
         end_sim();
      end
   endtask : wait_ready

   // Reset values, read-only and unmapped places
   task automatic t_regs();
      rd_chk(`REG_STATUS, 32'hffffffff, 32'h0);
      rd_chk(`REG_CTRL, 32'hffffffff, {31'h0, `CTRL_RST_VAL});
      wr_reg(4'h3, 32'hffffffff);
      rd_chk(4'h3, 32'hffffffff, 32'h0);
      wr_reg(`REG_STATUS, 32'hffffffff);
      rd_chk(`REG_STATUS, 32'hffffffff, 32'h0);
      wr_reg(`REG_CTRL, 32'h1);
      rd_chk(`REG_CTRL, 32'h1, 32'h1);
      wr_reg(`REG_CTRL, 32'h0);
      $display("test regs done");
   endtask : t_regs

   // Clean power-up, then mode register contents
   task automatic t_power_up();
      dram_ctrl_model_inst.run_init(0, 12);
      #1 chk({31'h0, ready}, 32'h0);
      wait_ready();
      rd_chk(`REG_STATUS, 32'h7fb, 32'h7fb);
      rd_chk(`REG_ERR, 32'h7fff, 32'h0);
      rd_chk(`REG_MR0, 32'h3fff, 32'h0);
      rd_chk(`REG_MR1, 32'h3fff, 32'h0);
      rd_chk(`REG_MR2, 32'h3fff, 32'h8);
      rd_chk(`REG_MR3, 32'h3fff, 32'h0);
      $display("test power up done");
   endtask : t_power_up

   // Idle rewrite, termination, mode sets with clock enable low or bad bank
   task automatic t_rewrite();
      dram_ctrl_model_inst.cmd(4'h0, 3'h1, 14'h0004, 13);
      rd_chk(`REG_MR1, 32'h3fff, 32'h4);
      dram_ctrl_model_inst.set_pins(1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge clk);
      #1 chk({31'h0, term_en}, 32'h1);
      rd_chk(`REG_STATUS, 32'h4, 32'h4);
      dram_ctrl_model_inst.set_pins(1'b1, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      #1 chk({31'h0, term_en}, 32'h0);
      dram_ctrl_model_inst.set_pins(1'b1, 1'b0, 1'b0);
      dram_ctrl_model_inst.cmd(4'h0, 3'h2, 14'h0008, 13);
      dram_ctrl_model_inst.set_pins(1'b1, 1'b1, 1'b0);
      wr_reg(`REG_CTRL, 32'h1);
      dram_ctrl_model_inst.cmd(4'h0, 3'h7, 14'h0155, 13);
      wr_reg(`REG_CTRL, 32'h0);
      rd_chk(`REG_MR3, 32'h3fff, 32'h0);
      rd_chk(`REG_ERR, 32'h7fff, 32'h3000);
      wr_reg(`REG_ERR, 32'h7fff);
      rd_chk(`REG_ERR, 32'h7fff, 32'h0);
      $display("test rewrite done");
   endtask : t_rewrite

   // Each controller fault at stable-power reset raises its flag
   task automatic t_faults();
      int f [5] = '{1, 2, 3, 4, 5};
      int b [5] = '{`ERR_ORDER, `ERR_CKE_EARLY, `ERR_MRD, `ERR_INIT_BITS, `ERR_MOD};
      foreach (f[i]) begin
         wr_reg(`REG_ERR, 32'h7fff);
         dram_ctrl_model_inst.run_init(f[i], 4);
         repeat (4) @(posedge clk);
         rd_chk(`REG_ERR, (32'h1 << b[i]) | 32'h1, 32'h1 << b[i]);
         chk({31'h0, err}, 32'h1);
         wr_reg(`REG_ERR, 32'h7fff);
         repeat (2) @(posedge clk);
         #1 chk({31'h0, err}, 32'h0);
      end
      $display("test faults done");
   endtask : t_faults

   // Power-up reset shorter than the minimum
   task automatic t_short_pwr();
      dram_ctrl_model_inst.set_pins(1'b0, 1'b0, 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      dram_ctrl_model_inst.run_init(0, 5);
      rd_chk(`REG_ERR, 32'h3, 32'h1);
      $display("test short reset done");
   endtask : t_short_pwr

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_power_up();
      t_rewrite();
      t_faults();
      t_short_pwr();
      end_sim();
   end
endmodule : test_dram_init_and_mode_register_seq

bind dram_init_seq dram_init_props dram_init_props_inst (.i_clk, .i_rst, .i_reset_n, .i_cke,
   .i_wr, .i_rd, .o_rdata, .o_ready, .o_dll_locked, .o_term_en, .o_err);
